// ### core/mafa_core.v
// Mirror and frame averaging core: AOI crop on binned input, per-pixel
// averaging over triggered exposures, and line mirroring on output.
// Assumes the input stream is already binned, one pixel per clock at most,
// with end-of-line and end-of-frame marked on the last pixel.
//
// How it works
// R1: Virtual size is physical size divided by binning, fraction dropped.
// R2: AOI counted in binned columns and lines, clamped to virtual size.
// R3: Readout line count uses AOI height in binned lines when binning on.
// R4: Mirror reverses pixel order of every output line.
// R5: AOI crop happens on sensor positions before mirroring.
// R6: Color variant swaps pixel pairs so mosaic phase stays unchanged; code keeps this on even AOI widths only.
// R7: Auto window samples fixed sensor positions, independent of mirroring.
// R8: One control bit turns line mirroring on or off.
// R9: Sequencer enabled forces averaging off.
// R10: Averaging count accepts up to 256 exposures.
// R11: Per pixel sum divided by count, integer quotient output.
// R12: Averaging works for any acquisition and trigger mode.
// R13: Each exposure has its own trigger; the device counts them.
// R14: Single frame mode yields one averaged frame after count exposures.
// R15: Setting changes apply at once, even mid-sequence.
// R16: Software should not change settings during an averaging set.
// R17: One exposure-end event per exposure, none for the average.
// R18: Averaged frame carries chunk of its final exposure; code gives the previous set's chunk if the AOI ends before the last line.
// R19: One output frame per count exposures.
// R20: Count of one passes every exposure through.
// R21: Accumulator wide enough for 256 full-scale pixels.
// R22: New set starts with cleared sums and exposure counter.
`timescale 1ns/1ps
`include "mafa_consts.vh"

module mafa_core (
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        seq_enable_i,
  input  wire        acq_start_i,
  input  wire        trig_i,
  input  wire        exp_end_i,
  input  wire [31:0] chunk_i,
  input  wire        pix_valid_i,
  input  wire [11:0] pix_data_i,
  input  wire        pix_eol_i,
  input  wire        pix_eof_i,
  output reg         out_valid_o,
  output reg  [11:0] out_data_o,
  output reg         out_sof_o,
  output reg         out_eol_o,
  output reg         out_eof_o,
  output reg         exp_end_evt_o,
  output reg         chunk_valid_o,
  output reg  [31:0] chunk_o,
  output reg  [11:0] virt_width_o,
  output reg  [11:0] virt_height_o,
  output reg  [11:0] readout_lines_o
);

  localparam RD_IDLE = 2'b01;
  localparam RD_RUN  = 2'b10;

  // Software settings
  reg  [3:0]  ctrl_q;
  reg  [2:0]  bin_h_q;
  reg  [2:0]  bin_v_q;
  reg  [11:0] aoi_x_q;
  reg  [11:0] aoi_w_q;
  reg  [11:0] aoi_y_q;
  reg  [11:0] aoi_h_q;
  reg  [8:0]  avg_cnt_q;
  reg  [11:0] afw_x_q;
  reg  [11:0] afw_w_q;
  reg  [11:0] afw_y_q;
  reg  [11:0] afw_h_q;

  // Input position and averaging state
  reg  [11:0] col_q;
  reg  [11:0] line_q;
  reg  [18:0] pidx_q;
  reg  [7:0]  exp_q;
  reg  [8:0]  trig_q;
  reg  [31:0] af_acc_q;
  reg  [31:0] af_sum_q;
  reg  [31:0] chunk_hold_q;
  reg  [19:0] acc_mem [0:`MAFA_FRAME_PIX-1];

  // Line buffer, two banks of one line each
  reg  [11:0] line_mem [0:2*`MAFA_MAXW-1];
  reg         wbank_q;
  reg  [11:0] wcol_q;
  reg         pend_q;
  reg         pend_bank_q;
  reg  [11:0] pend_len_q;
  reg         pend_sof_q;
  reg         pend_eof_q;
  reg  [1:0]  rd_state_q;
  reg         rd_bank_q;
  reg  [11:0] rd_idx_q;
  reg  [11:0] rd_len_q;
  reg         rd_sof_q;
  reg         rd_eof_q;
  reg         rd_mir_q;
  reg         rd_col_q;

  wire [2:0]  bin_h = (bin_h_q == 3'h0) ? 3'h1 : bin_h_q;
  wire [2:0]  bin_v = (bin_v_q == 3'h0) ? 3'h1 : bin_v_q;
  // Remainder of the division is simply lost [R1]
  wire [11:0] vw = `MAFA_PHYS_W / {9'h000, bin_h};
  wire [11:0] vh = `MAFA_PHYS_H / {9'h000, bin_v};

  // AOI clamped to the virtual sensor, all in binned units [R2]
  wire [11:0] x_eff = (aoi_x_q < vw) ? aoi_x_q : vw - 12'h001;
  wire [11:0] y_eff = (aoi_y_q < vh) ? aoi_y_q : vh - 12'h001;
  wire [12:0] x_end = {1'b0, x_eff} + {1'b0, aoi_w_q};
  wire [12:0] y_end = {1'b0, y_eff} + {1'b0, aoi_h_q};
  wire [11:0] w_eff = (aoi_w_q == 12'h000) ? 12'h001 :
                      (x_end > {1'b0, vw}) ? vw - x_eff : aoi_w_q;
  wire [11:0] h_eff = (aoi_h_q == 12'h000) ? 12'h001 :
                      (y_end > {1'b0, vh}) ? vh - y_eff : aoi_h_q;

  // Window test on sensor positions, so mirroring never moves the AOI [R5]
  wire        in_col = (col_q >= x_eff) &&
                       ({1'b0, col_q} < {1'b0, x_eff} + {1'b0, w_eff});
  wire        in_line = (line_q >= y_eff) &&
                        ({1'b0, line_q} < {1'b0, y_eff} + {1'b0, h_eff});
  wire        in_win = pix_valid_i && in_col && in_line;
  wire        last_line = ({1'b0, line_q} ==
                           {1'b0, y_eff} + {1'b0, h_eff} - 13'h0001);

  // Sequencer wins over any count; a count of one passes through [R9] [R20]
  wire        avg_on = ~seq_enable_i && (avg_cnt_q > 9'h001);
  wire [8:0]  n_eff = avg_on ? avg_cnt_q : 9'h001;
  // Live compare, so a count lowered mid-set ends the set at once [R15]
  wire        first_exp = (exp_q == 8'h00);
  wire        last_exp = ({1'b0, exp_q} >= n_eff - 9'h001);
  wire        frame_end = pix_valid_i && pix_eof_i;

  // Accumulate and divide; 20 bits hold 256 times 4095 [R11] [R21]
  wire [19:0] acc_old = first_exp ? 20'h00000 : acc_mem[pidx_q];
  wire [19:0] acc_sum = acc_old + {8'h00, pix_data_i};
  wire [19:0] avg_full = acc_sum / {11'h000, n_eff};
  wire [11:0] avg_pix = avg_full[11:0];
  wire        emit_pix = in_win && last_exp;

  // Auto window on raw sensor positions, before any mirroring [R7]
  wire        af_in = pix_valid_i &&
                      (col_q >= afw_x_q) &&
                      ({1'b0, col_q} < {1'b0, afw_x_q} + {1'b0, afw_w_q}) &&
                      (line_q >= afw_y_q) &&
                      ({1'b0, line_q} < {1'b0, afw_y_q} + {1'b0, afw_h_q});

  // Line buffer addressing; color variant flips bit 0 on mirrored reads
  wire [11:0] rev_idx = rd_len_q - 12'h001 - rd_idx_q;
  wire [11:0] mir_idx = rev_idx ^ {11'h000, rd_col_q};
  wire [11:0] rd_col = rd_mir_q ? mir_idx : rd_idx_q;
  wire [10:0] rd_addr = rd_bank_q ? (rd_col[10:0] + 11'd648) : rd_col[10:0];
  wire [10:0] wr_addr = wbank_q ? (wcol_q[10:0] + 11'd648) : wcol_q[10:0];
  wire        line_done = pix_valid_i && pix_eol_i && last_exp &&
                          in_line && (wcol_q != 12'h000 || in_win);
  wire        rd_start = (rd_state_q == RD_IDLE) && pend_q;
  wire        rd_last = (rd_state_q == RD_RUN) &&
                        (rd_idx_q == rd_len_q - 12'h001);

  // Register writes; binning and count clamped to their legal ranges
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q    <= `MAFA_RST_CTRL;
      bin_h_q   <= `MAFA_RST_BIN;
      bin_v_q   <= `MAFA_RST_BIN;
      aoi_x_q   <= 12'h000;
      aoi_w_q   <= `MAFA_PHYS_W;
      aoi_y_q   <= 12'h000;
      aoi_h_q   <= `MAFA_PHYS_H;
      avg_cnt_q <= `MAFA_RST_AVG;
      afw_x_q   <= 12'h000;
      afw_w_q   <= `MAFA_PHYS_W;
      afw_y_q   <= 12'h000;
      afw_h_q   <= `MAFA_PHYS_H;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `MAFA_OFF_CTRL:  ctrl_q <= reg_wdata_i[3:0]; // [R8]
        `MAFA_OFF_BIN: begin
          bin_h_q <= (reg_wdata_i[2:0] > `MAFA_BIN_MAX) ?
                     `MAFA_BIN_MAX : reg_wdata_i[2:0];
          bin_v_q <= (reg_wdata_i[6:4] > `MAFA_BIN_MAX) ?
                     `MAFA_BIN_MAX : reg_wdata_i[6:4];
        end
        `MAFA_OFF_AOI_X: aoi_x_q <= reg_wdata_i[11:0];
        `MAFA_OFF_AOI_W: aoi_w_q <= reg_wdata_i[11:0];
        `MAFA_OFF_AOI_Y: aoi_y_q <= reg_wdata_i[11:0];
        `MAFA_OFF_AOI_H: aoi_h_q <= reg_wdata_i[11:0];
        `MAFA_OFF_AVG_CNT: begin
          // Zero in the low nine bits reads back as one; other values above 256 are held at 256 [R10]
          if (reg_wdata_i[8:0] == 9'h000)
            avg_cnt_q <= 9'h001;
          else if (reg_wdata_i[31:0] > {23'h000000, `MAFA_AVG_MAX})
            avg_cnt_q <= `MAFA_AVG_MAX;
          else
            avg_cnt_q <= reg_wdata_i[8:0];
        end
        `MAFA_OFF_AFW_X: afw_x_q <= reg_wdata_i[11:0];
        `MAFA_OFF_AFW_W: afw_w_q <= reg_wdata_i[11:0];
        `MAFA_OFF_AFW_Y: afw_y_q <= reg_wdata_i[11:0];
        `MAFA_OFF_AFW_H: afw_h_q <= reg_wdata_i[11:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads 0
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `MAFA_OFF_CTRL:     reg_rdata_o <= {28'h0000000, ctrl_q};
        `MAFA_OFF_BIN:      reg_rdata_o <= {25'h0000000, bin_v_q, 1'b0,
                                            bin_h_q};
        `MAFA_OFF_AOI_X:    reg_rdata_o <= {20'h00000, aoi_x_q};
        `MAFA_OFF_AOI_W:    reg_rdata_o <= {20'h00000, aoi_w_q};
        `MAFA_OFF_AOI_Y:    reg_rdata_o <= {20'h00000, aoi_y_q};
        `MAFA_OFF_AOI_H:    reg_rdata_o <= {20'h00000, aoi_h_q};
        `MAFA_OFF_AVG_CNT:  reg_rdata_o <= {23'h000000, avg_cnt_q};
        `MAFA_OFF_VSIZE:    reg_rdata_o <= {4'h0, vh, 4'h0, vw}; // [R1]
        `MAFA_OFF_RD_LINES: reg_rdata_o <= {20'h00000, h_eff};
        `MAFA_OFF_STATUS:   reg_rdata_o <= {7'h00, avg_on, 7'h00, trig_q,
                                            exp_q};
        `MAFA_OFF_AFW_X:    reg_rdata_o <= {20'h00000, afw_x_q};
        `MAFA_OFF_AFW_W:    reg_rdata_o <= {20'h00000, afw_w_q};
        `MAFA_OFF_AFW_Y:    reg_rdata_o <= {20'h00000, afw_y_q};
        `MAFA_OFF_AFW_H:    reg_rdata_o <= {20'h00000, afw_h_q};
        `MAFA_OFF_AF_SUM:   reg_rdata_o <= af_sum_q;
        default:            reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // Geometry outputs follow the binning and AOI settings directly
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      virt_width_o    <= `MAFA_PHYS_W;
      virt_height_o   <= `MAFA_PHYS_H;
      readout_lines_o <= `MAFA_PHYS_H;
    end else begin
      virt_width_o    <= vw; // [R1]
      virt_height_o   <= vh; // [R1]
      // Already binned lines when binning is on, physical otherwise
      readout_lines_o <= h_eff; // [R3]
    end
  end

  // Sensor position counters; a restart drops any partial frame
  always @(posedge ref_clk_i) begin
    if (!rst_n_i || acq_start_i) begin
      col_q  <= 12'h000;
      line_q <= 12'h000;
      pidx_q <= 19'h00000;
    end else if (pix_valid_i) begin
      if (pix_eof_i) begin
        col_q  <= 12'h000;
        line_q <= 12'h000;
        pidx_q <= 19'h00000;
      end else if (pix_eol_i) begin
        col_q  <= 12'h000;
        line_q <= line_q + 12'h001;
        pidx_q <= in_win ? pidx_q + 19'h00001 : pidx_q;
      end else begin
        col_q  <= col_q + 12'h001;
        pidx_q <= in_win ? pidx_q + 19'h00001 : pidx_q;
      end
    end
  end

  // Per pixel sums; the first exposure overwrites, so no clear pass [R22]
  always @(posedge ref_clk_i) begin
    if (in_win && pidx_q < 19'd316224)
      acc_mem[pidx_q] <= acc_sum; // [R11]
  end

  // Exposure and trigger counters; each set ends after count frames
  always @(posedge ref_clk_i) begin
    if (!rst_n_i || acq_start_i) begin
      exp_q  <= 8'h00; // [R22]
      trig_q <= 9'h000;
    end else begin
      if (frame_end)
        exp_q <= last_exp ? 8'h00 : exp_q + 8'h01; // [R14] [R19]
      // Trigger count restarts when the set closes, a new trigger still counts
      if (frame_end && last_exp)
        trig_q <= {8'h00, trig_i}; // [R13]
      else if (trig_i)
        trig_q <= trig_q + 9'h001; // [R13] [R12]
    end
  end

  // Exposure-end events pass one per exposure, never for the average
  always @(posedge ref_clk_i) begin
    if (!rst_n_i)
      exp_end_evt_o <= 1'b0;
    else
      exp_end_evt_o <= exp_end_i && ctrl_q[`MAFA_CTRL_EVT_EN]; // [R17]
  end

  // Chunk of the closing exposure is kept for the averaged frame
  always @(posedge ref_clk_i) begin
    if (!rst_n_i)
      chunk_hold_q <= 32'h00000000;
    else if (frame_end && last_exp)
      chunk_hold_q <= chunk_i; // [R18]
  end

  // Auto window sum, latched at each frame end
  always @(posedge ref_clk_i) begin
    if (!rst_n_i || acq_start_i) begin
      af_acc_q <= 32'h00000000;
      af_sum_q <= 32'h00000000;
    end else if (frame_end) begin
      af_acc_q <= 32'h00000000;
      af_sum_q <= af_acc_q + (af_in ? {20'h00000, pix_data_i} : 32'h0); // [R7]
    end else if (af_in) begin
      af_acc_q <= af_acc_q + {20'h00000, pix_data_i};
    end
  end

  // Line buffer write, only on the closing exposure of a set
  always @(posedge ref_clk_i) begin
    if (emit_pix)
      line_mem[wr_addr] <= avg_pix;
  end

  // Write side bank control; a new line wins over a same-cycle handoff
  always @(posedge ref_clk_i) begin
    if (!rst_n_i || acq_start_i) begin
      wbank_q     <= 1'b0;
      wcol_q      <= 12'h000;
      pend_q      <= 1'b0;
      pend_bank_q <= 1'b0;
      pend_len_q  <= 12'h000;
      pend_sof_q  <= 1'b0;
      pend_eof_q  <= 1'b0;
    end else begin
      if (line_done) begin
        wbank_q     <= ~wbank_q;
        wcol_q      <= 12'h000;
        pend_q      <= 1'b1;
        pend_bank_q <= wbank_q;
        pend_len_q  <= wcol_q + {11'h000, in_win};
        pend_sof_q  <= (line_q == y_eff);
        pend_eof_q  <= last_line || pix_eof_i;
      end else begin
        if (pix_valid_i && pix_eol_i)
          wcol_q <= 12'h000;
        else if (emit_pix)
          wcol_q <= wcol_q + 12'h001;
        if (rd_start)
          pend_q <= 1'b0;
      end
    end
  end

  // Readout state; mirror and color are sampled once per line
  always @(posedge ref_clk_i) begin
    if (!rst_n_i || acq_start_i) begin
      rd_state_q <= RD_IDLE;
      rd_bank_q  <= 1'b0;
      rd_idx_q   <= 12'h000;
      rd_len_q   <= 12'h000;
      rd_sof_q   <= 1'b0;
      rd_eof_q   <= 1'b0;
      rd_mir_q   <= 1'b0;
      rd_col_q   <= 1'b0;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          if (pend_q) begin
            rd_state_q <= RD_RUN;
            rd_bank_q  <= pend_bank_q;
            rd_idx_q   <= 12'h000;
            rd_len_q   <= pend_len_q;
            rd_sof_q   <= pend_sof_q;
            rd_eof_q   <= pend_eof_q;
            rd_mir_q   <= ctrl_q[`MAFA_CTRL_MIRROR]; // [R4] [R8]
            // Pair swap keeps mosaic phase on even widths [R6]
            rd_col_q   <= ctrl_q[`MAFA_CTRL_MIRROR] &
                          ctrl_q[`MAFA_CTRL_COLOR];
          end
        end
        RD_RUN: begin
          if (rd_last)
            rd_state_q <= RD_IDLE;
          rd_idx_q <= rd_idx_q + 12'h001;
        end
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

  // Output stream from the line buffer, reversed when mirrored [R4]
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      out_valid_o   <= 1'b0;
      out_data_o    <= 12'h000;
      out_sof_o     <= 1'b0;
      out_eol_o     <= 1'b0;
      out_eof_o     <= 1'b0;
      chunk_valid_o <= 1'b0;
      chunk_o       <= 32'h00000000;
    end else begin
      out_valid_o <= (rd_state_q == RD_RUN);
      out_data_o  <= (rd_state_q == RD_RUN) ? line_mem[rd_addr] : 12'h000;
      out_sof_o   <= (rd_state_q == RD_RUN) && rd_sof_q &&
                     (rd_idx_q == 12'h000);
      out_eol_o   <= rd_last;
      out_eof_o   <= rd_last && rd_eof_q;
      // Chunk rides with the last pixel of the averaged frame [R18]
      chunk_valid_o <= rd_last && rd_eof_q && ctrl_q[`MAFA_CTRL_CHUNK_EN];
      if (rd_last && rd_eof_q)
        chunk_o <= chunk_hold_q;
    end
  end

endmodule

// ### core/mafa_consts.vh
// Constants for the mirror and frame averaging block: register offsets,
// field positions, reset values and fixed geometry.
// Assumes inclusion by bare name from the design, checker and bench files.
`ifndef MAFA_CONSTS_VH
`define MAFA_CONSTS_VH

// Register byte offsets (one aligned word each)
`define MAFA_OFF_CTRL       8'h00
`define MAFA_OFF_BIN        8'h04
`define MAFA_OFF_AOI_X      8'h08
`define MAFA_OFF_AOI_W      8'h0c
`define MAFA_OFF_AOI_Y      8'h10
`define MAFA_OFF_AOI_H      8'h14
`define MAFA_OFF_AVG_CNT    8'h18
`define MAFA_OFF_VSIZE      8'h1c
`define MAFA_OFF_RD_LINES   8'h20
`define MAFA_OFF_STATUS     8'h24
`define MAFA_OFF_AFW_X      8'h28
`define MAFA_OFF_AFW_W      8'h2c
`define MAFA_OFF_AFW_Y      8'h30
`define MAFA_OFF_AFW_H      8'h34
`define MAFA_OFF_AF_SUM     8'h38

// Control register fields
`define MAFA_CTRL_MIRROR    0
`define MAFA_CTRL_COLOR     1
`define MAFA_CTRL_EVT_EN    2
`define MAFA_CTRL_CHUNK_EN  3

// Reset values
`define MAFA_RST_CTRL       4'h0
`define MAFA_RST_BIN        3'h1
`define MAFA_RST_AVG        9'h001

// Geometry and widths
`define MAFA_PHYS_W         12'h288
`define MAFA_PHYS_H         12'h1e8
`define MAFA_MAXW           648
`define MAFA_FRAME_PIX      316224
`define MAFA_BIN_MAX        3'h4
`define MAFA_AVG_MAX        9'h100

`endif

// ### tb/mafa_core_props.sv
// Checker for the mirror and frame averaging core, top ports only.
// Assumes it is bound to the core from the testbench top file.
`timescale 1ns/1ps
`include "mafa_consts.vh"
module mafa_core_chk (
  input wire        ref_clk_i,
  input wire        rst_n_i,
  input wire [7:0]  reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire        seq_enable_i,
  input wire        exp_end_i,
  input wire        pix_valid_i,
  input wire        pix_eol_i,
  input wire        pix_eof_i,
  input wire        out_valid_o,
  input wire [11:0] out_data_o,
  input wire        out_sof_o,
  input wire        out_eof_o,
  input wire        exp_end_evt_o,
  input wire        chunk_valid_o,
  input wire [11:0] virt_width_o,
  input wire [11:0] virt_height_o
);
  logic       evt_en_q;
  logic       avg_one_q;
  logic [2:0] bin_h_q;
  logic [2:0] bin_v_q;
  // Decoded writes; bin_ok skips values the core would clamp
  wire wr_bin = reg_wr_i && reg_addr_i == `MAFA_OFF_BIN;
  wire wr_avg = reg_wr_i && reg_addr_i == `MAFA_OFF_AVG_CNT;
  wire eol_in = pix_valid_i && pix_eol_i;
  wire bin_ok = (|reg_wdata_i[2:0]) && reg_wdata_i[2:0] <= 3'h4 &&
                (|reg_wdata_i[6:4]) && reg_wdata_i[6:4] <= 3'h4;
  // Shadow copies of the settings that gate the checked outputs
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      evt_en_q  <= 1'b0;
      avg_one_q <= 1'b1;
      bin_h_q   <= 3'h1;
      bin_v_q   <= 3'h1;
    end else begin
      if (reg_wr_i && reg_addr_i == `MAFA_OFF_CTRL)
        evt_en_q <= reg_wdata_i[`MAFA_CTRL_EVT_EN];
      if (wr_avg)
        avg_one_q <= (reg_wdata_i < 32'h2);
      if (wr_bin && bin_ok) begin
        bin_h_q <= reg_wdata_i[2:0];
        bin_v_q <= reg_wdata_i[6:4];
      end
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Over-range count write, then its read back
  sequence avg_over_wr;
    wr_avg && reg_wdata_i > 32'h100;
  endsequence
  sequence avg_rd;
    reg_rd_i && reg_addr_i == `MAFA_OFF_AVG_CNT;
  endsequence
  // A frame end that must come out on its own
  sequence pass_frame_in;
    (seq_enable_i || avg_one_q) && pix_valid_i && pix_eof_i;
  endsequence
  evt_gate_a: assert property (exp_end_i && evt_en_q |=>
    exp_end_evt_o) else $error("exposure end event missing");
  evt_cause_a: assert property (exp_end_evt_o |->
    $past(exp_end_i)) else $error("exposure end event without cause");
  vsize_bin_a: assert property (wr_bin && bin_ok |=> ##[0:1]
    (virt_width_o == 12'd648 / bin_h_q &&
     virt_height_o == 12'd488 / bin_v_q)) else $error("virtual size wrong");
  avg_clamp_a: assert property (avg_over_wr ##1 avg_rd |=>
    reg_rdata_o == 32'h100) else $error("count not clamped");
  pass_thru_a: assert property (pass_frame_in |->
    ##[2:660] out_eof_o) else $error("frame not passed through");
  chunk_eof_a: assert property (chunk_valid_o |-> out_eof_o)
    else $error("chunk outside frame end");
  sof_gap_a: assert property (out_sof_o |-> $past(eol_in, 3))
    else $error("line readout latency wrong");
  idle_data_a: assert property (!out_valid_o |-> out_data_o == 12'h0)
    else $error("pixel data while idle");
endmodule

// ### tb/mafa_pix_src.sv
// Model of the readout path feeding the core: one 4-pixel line per exposure.
// Assumes frame is entered just after a rising clock edge.
`timescale 1ns/1ps
module mafa_pix_src (
  input  wire         clk_i,
  output logic        trig_o,
  output logic        exp_end_o,
  output logic        valid_o,
  output logic [11:0] data_o,
  output logic        eol_o,
  output logic        eof_o,
  output logic [31:0] chunk_o
);
  // Idle lines; data never rests at a real pixel value
  initial begin
    trig_o    = 1'b0;
    exp_end_o = 1'b0;
    valid_o   = 1'b0;
    data_o    = 12'h5a5;
    eol_o     = 1'b0;
    eof_o     = 1'b0;
    chunk_o   = 32'h0;
  end
  // Gap sets how slowly the next exposure follows
  task automatic frame(input logic [47:0] px, input logic [31:0] ck,
                       input int gap);
    trig_o <= 1'b1;
    @(posedge clk_i);
    trig_o <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      valid_o <= 1'b1;
      data_o  <= px[i*12 +: 12];
      eol_o   <= (i == 3);
      eof_o   <= (i == 3);
      chunk_o <= (i == 3) ? ck : ~ck;
      @(posedge clk_i);
    end
    valid_o   <= 1'b0;
    eol_o     <= 1'b0;
    eof_o     <= 1'b0;
    data_o    <= ~px[47:36];
    chunk_o   <= ~ck;
    exp_end_o <= 1'b1;
    @(posedge clk_i);
    exp_end_o <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask
endmodule

// ### tb/test_mirror_and_frame_averaging.sv
// Self-checking bench for the mirror and frame averaging core.
// Assumes the core, its constants header, the checker and the pixel model.
`timescale 1ns/1ps
`include "mafa_consts.vh"
module test_mirror_and_frame_averaging;
  logic        ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, seq_enable_i;
  logic        acq_start_i, trig_i, exp_end_i, pix_valid_i, pix_eol_i;
  logic        pix_eof_i, out_valid_o, out_sof_o, out_eol_o, out_eof_o;
  logic        exp_end_evt_o, chunk_valid_o, rd_seen;
  logic [7:0]  reg_addr_i;
  logic [11:0] pix_data_i, out_data_o, virt_width_o, virt_height_o;
  logic [11:0] readout_lines_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, chunk_i, chunk_o;
  logic [31:0] rq[$], cq[$];
  logic [11:0] pq[$];
  logic [1:0]  md_t[4] = '{2'h0, 2'h1, 2'h3, 2'h1};
  int          cnt_t[4] = '{1, 3, 2, 256};
  int          err_total = 0, checks = 0, evt_n = 0, tot = 0, cyc = 0;
  integer      seed = 32'h66b6bf5a;

  mafa_core u_mafa_core (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .seq_enable_i(seq_enable_i),
    .acq_start_i(acq_start_i), .trig_i(trig_i), .exp_end_i(exp_end_i),
    .chunk_i(chunk_i), .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i),
    .pix_eol_i(pix_eol_i), .pix_eof_i(pix_eof_i), .out_valid_o(out_valid_o),
    .out_data_o(out_data_o), .out_sof_o(out_sof_o), .out_eol_o(out_eol_o),
    .out_eof_o(out_eof_o), .exp_end_evt_o(exp_end_evt_o),
    .chunk_valid_o(chunk_valid_o), .chunk_o(chunk_o),
    .virt_width_o(virt_width_o), .virt_height_o(virt_height_o),
    .readout_lines_o(readout_lines_o)
  );
  mafa_pix_src u_mafa_pix_src (
    .clk_i(ref_clk_i), .trig_o(trig_i), .exp_end_o(exp_end_i),
    .valid_o(pix_valid_i), .data_o(pix_data_i), .eol_o(pix_eol_i),
    .eof_o(pix_eof_i), .chunk_o(chunk_i)
  );
  // 10 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task cmp_w(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_px(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus cycle; on a read d is the expected data
  task bus(input logic wr, input logic rd, input logic [7:0] a,
           input logic [31:0] d);
    reg_wr_i    <= wr;
    reg_rd_i    <= rd;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    if (rd) rq.push_back(d);
    @(posedge ref_clk_i);
  endtask
  task idle(input int n);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
  endtask
  // One averaging set; notes are made before the closing exposure
  task run_set(input logic [1:0] md, input int n);
    logic [19:0] sum[4];
    logic [47:0] px;
    logic [31:0] ck;
    int          j;
    for (int i = 0; i < 4; i++) sum[i] = 20'h0;
    for (int f = 0; f < n; f++) begin
      px = 48'({$random(seed), $random(seed)});
      ck = $random(seed);
      for (int i = 0; i < 4; i++) sum[i] += px[i*12 +: 12];
      if (f == n - 1) begin
        for (int i = 0; i < 4; i++) begin
          j = md[0] ? (md[1] ? 3 - (i ^ 1) : 3 - i) : i;
          pq.push_back(12'(sum[j] / n));
        end
        cq.push_back(ck);
      end
      u_mafa_pix_src.frame(px, ck, 3 + f % 8);
      tot++;
    end
  endtask
  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Takes the oldest note whenever a result appears; cuts a hang short
  always @(posedge ref_clk_i) begin
    if (rd_seen) cmp_w(reg_rdata_o, rq.pop_front());
    if (out_valid_o) cmp_px(out_data_o, pq.pop_front());
    if (chunk_valid_o) cmp_w(chunk_o, cq.pop_front());
    if (out_eof_o) cmp_w(32'(out_eol_o), 32'h1);
    if (exp_end_evt_o) evt_n++;
    rd_seen = reg_rd_i;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // Main sequence; settings only change between sets
  initial begin
    rst_n_i      = 1'b0;
    reg_wr_i     = 1'b0;
    reg_rd_i     = 1'b0;
    reg_addr_i   = 8'h0;
    reg_wdata_i  = 32'h0;
    seq_enable_i = 1'b0;
    acq_start_i  = 1'b0;
    rd_seen      = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    bus(0, 1, `MAFA_OFF_VSIZE, 32'h01e8_0288);
    bus(1, 0, `MAFA_OFF_BIN, 32'h33);
    idle(2);
    bus(0, 1, `MAFA_OFF_VSIZE, 32'h00a2_00d8);
    bus(1, 0, `MAFA_OFF_BIN, 32'h77);
    idle(2);
    bus(0, 1, `MAFA_OFF_VSIZE, 32'h007a_00a2);
    bus(1, 0, `MAFA_OFF_BIN, 32'h11);
    bus(1, 0, `MAFA_OFF_AVG_CNT, 32'h1ff);
    bus(0, 1, `MAFA_OFF_AVG_CNT, 32'h100);
    bus(1, 0, `MAFA_OFF_AVG_CNT, 32'h0);
    bus(0, 1, `MAFA_OFF_AVG_CNT, 32'h1);
    bus(0, 1, 8'hfc, 32'h0);
    bus(1, 0, `MAFA_OFF_AOI_W, 32'h4);
    bus(1, 0, `MAFA_OFF_AOI_H, 32'h1);
    idle(3);
    cmp_w(32'(readout_lines_o), 32'h1);
    $display("register test done");
    for (int t = 0; t < 4; t++) begin
      bus(1, 0, `MAFA_OFF_CTRL, {28'h0, 2'b11, md_t[t]});
      bus(1, 0, `MAFA_OFF_AVG_CNT, 32'(cnt_t[t]));
      idle(1);
      if (cnt_t[t] > 1) begin
        u_mafa_pix_src.frame(48'hfff_fff_fff_fff, 32'h0, 4);
        tot++;
        bus(0, 1, `MAFA_OFF_STATUS, 32'h0100_0101);
        acq_start_i <= 1'b1;
        idle(1);
        acq_start_i <= 1'b0;
      end
      run_set(md_t[t], cnt_t[t]);
      $display("averaging test %0d done", t);
    end
    // Sequencer on: a count of three must not hold frames back
    seq_enable_i <= 1'b1;
    bus(1, 0, `MAFA_OFF_AVG_CNT, 32'h3);
    idle(1);
    run_set(2'h1, 1);
    run_set(2'h1, 1);
    seq_enable_i <= 1'b0;
    idle(10);
    $display("sequencer test done");
    cmp_w(32'(evt_n), 32'(tot));
    cmp_w(32'(pq.size() + cq.size()), 32'h0);
    tally_and_finish();
  end
endmodule

bind mafa_core mafa_core_chk u_mafa_core_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .seq_enable_i(seq_enable_i),
  .exp_end_i(exp_end_i), .pix_valid_i(pix_valid_i), .pix_eol_i(pix_eol_i),
  .pix_eof_i(pix_eof_i), .out_valid_o(out_valid_o),
  .out_data_o(out_data_o), .out_sof_o(out_sof_o), .out_eof_o(out_eof_o),
  .exp_end_evt_o(exp_end_evt_o), .chunk_valid_o(chunk_valid_o),
  .virt_width_o(virt_width_o), .virt_height_o(virt_height_o)
);
